// [core/odsc_consts.svh]
// Constants for the opcode decoder and execution-state calculator.
// Assumes inclusion by bare name from the core/ folder.
`ifndef ODSC_CONSTS_SVH
`define ODSC_CONSTS_SVH

// First-byte field of the first instruction word
`define ODSC_FB_HI 15
`define ODSC_FB_LO 8
`define ODSC_PAIR_BIT 7
`define ODSC_BRANCH_NIBBLE 4'h4

// Peripheral transfer encodings, told apart by bits below bit 7
`define ODSC_OPC_PERIPH 8'h6A
`define ODSC_PERIPH_SUB 3'h4

// States taken by one cycle
`define ODSC_ST_ONCHIP 6'h02
`define ODSC_ST_INTERNAL 6'h01
`define ODSC_ST_REG_BYTE 6'h03
`define ODSC_ST_REG_WORD 6'h06
`define ODSC_ST_EXT_BYTE_BASE 6'h03
`define ODSC_ST_EXT_WORD_BASE 6'h06

// Reset values
`define ODSC_RST_STATES 16'h0000

`endif

// [core/odsc_pkg.sv]
// Types for the opcode decoder and execution-state calculator.
// Assumes nothing beyond a SystemVerilog compiler.
package odsc_pkg;

	typedef enum logic [3:0] {
		GRP_ILLEGAL, GRP_CONTROL, GRP_CCR, GRP_ARITH, GRP_LOGIC, GRP_SHIFT,
		GRP_XFER, GRP_PERIPH_READ, GRP_PERIPH_WRITE, GRP_BRANCH, GRP_MULDIV,
		GRP_SUBR, GRP_JUMP, GRP_BIT
	} odsc_group_type;

	// Order matches low nibble 0 to F of the short jumps
	typedef enum logic [3:0] {
		COND_ALWAYS, COND_NEVER, COND_HIGHER, COND_LOWER_SAME,
		COND_CARRY_CLEAR, COND_CARRY_SET, COND_NOT_EQUAL, COND_EQUAL,
		COND_OVF_CLEAR, COND_OVF_SET, COND_PLUS, COND_MINUS,
		COND_GREATER_EQUAL, COND_LESS, COND_GREATER, COND_LESS_EQUAL
	} odsc_cond_type;

	typedef enum logic [1:0] {
		LOC_ONCHIP, LOC_REGFIELD, LOC_EXTERNAL
	} odsc_loc_type;

	typedef struct packed {
		logic [3:0] fetch;
		logic [3:0] branchRead;
		logic [3:0] stack;
		logic [3:0] byteAccess;
		logic [3:0] wordAccess;
		logic [3:0] internalOp;
	} odsc_counts_type;

	typedef struct packed {
		odsc_loc_type fetch;
		odsc_loc_type branchRead;
		odsc_loc_type stack;
		odsc_loc_type byteAccess;
		odsc_loc_type wordAccess;
	} odsc_locs_type;

	typedef struct packed {
		odsc_group_type group;
		odsc_cond_type cond;
		logic paired;
		logic variant;
	} odsc_decode_type;

	typedef struct packed {
		logic valid;
		odsc_decode_type dec;
		logic [15:0] execStates;
	} odsc_state_type;

endpackage

// [core/odsc_state_calc.sv]
// Combinational execution-state sum over the six cycle types.
// Assumes counts and locations are stable inputs from the same clock domain.
`timescale 1ns/10ps
`include "odsc_consts.svh"
module odsc_state_calc import odsc_pkg::*; (
	input wire odsc_counts_type counts,
	input wire odsc_locs_type locs,
	input wire logic [3:0] waitStates,
	output logic [15:0] execStates
);

	// States of one cycle from its access width and location
	function automatic logic [5:0] statesPerCycle(input logic isByte, input odsc_loc_type loc,
			input logic [3:0] m);
		logic [5:0] result;
		result = `ODSC_ST_ONCHIP;
		case (loc)
			LOC_REGFIELD: result = isByte ? `ODSC_ST_REG_BYTE : `ODSC_ST_REG_WORD;
			LOC_EXTERNAL: result = isByte ? 6'(`ODSC_ST_EXT_BYTE_BASE + {2'h0, m})
				: 6'(`ODSC_ST_EXT_WORD_BASE + {1'b0, m, 1'b0});
			default: result = `ODSC_ST_ONCHIP;
		endcase
		return result;
	endfunction

	function automatic logic [15:0] term(input logic [3:0] cnt, input logic [5:0] st);
		return 16'(16'(cnt) * 16'(st));
	endfunction

	// Zero counts contribute nothing
	always_comb begin
		execStates = term(counts.fetch, statesPerCycle(1'b0, locs.fetch, waitStates))
			+ term(counts.branchRead, statesPerCycle(1'b0, locs.branchRead, waitStates))
			+ term(counts.stack, statesPerCycle(1'b0, locs.stack, waitStates))
			+ term(counts.byteAccess, statesPerCycle(1'b1, locs.byteAccess, waitStates))
			+ term(counts.wordAccess, statesPerCycle(1'b0, locs.wordAccess, waitStates))
			+ term(counts.internalOp, `ODSC_ST_INTERNAL);
	end

endmodule // odsc_state_calc

// [core/odsc_decoder.sv]
// Top: first-word opcode decoder with execution-state count, one cycle latency.
// Assumes all inputs come from logic on ref_clk; no pin synchronising needed.
//
// Function
// - Group chosen from bits 15 to 8
// - Shared first byte split by bit 7
// - Nibble 4 rows: sixteen short jump conditions
// - Alias jumps decode identical to base jumps
// - Stack push/pop decode as register transfer
// - Peripheral transfers separated by later bits
// - States are sum of count times per-cycle
// - External: byte 3+m, word 6+2m
// - Register field: byte 3, word 6
// - On-chip cycles 2, internal cycles 1
// - Unlisted cycle types count as zero
`timescale 1ns/10ps
`include "odsc_consts.svh"
module odsc_decoder import odsc_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic instrValid,
	input wire logic [15:0] instrWord,
	input wire odsc_counts_type counts,
	input wire odsc_locs_type locs,
	input wire logic [3:0] waitStates,
	output logic decValid,
	output odsc_group_type group,
	output odsc_cond_type cond,
	output logic paired,
	output logic variant,
	output logic [15:0] execStates
);

	odsc_state_type state;
	odsc_state_type next_state;
	logic [15:0] sumStates;

	odsc_state_calc calc (
		.counts(counts),
		.locs(locs),
		.waitStates(waitStates),
		.execStates(sumStates)
	);

	// Groups of first bytes whose high nibble is not the short jump row
	function automatic odsc_group_type rowGroup(input logic [7:0] fb, input logic [15:0] w);
		odsc_group_type g;
		g = GRP_ILLEGAL;
		case (fb[7:4])
			4'h0: begin
				case (fb[3:0])
					4'h0, 4'h1: g = GRP_CONTROL;
					4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: g = GRP_CCR;
					4'hC, 4'hD: g = GRP_XFER;
					default: g = GRP_ARITH;
				endcase
			end
			4'h1: begin
				case (fb[3:0])
					4'h0, 4'h1, 4'h2, 4'h3: g = GRP_SHIFT;
					4'h4, 4'h5, 4'h6, 4'h7: g = GRP_LOGIC;
					4'hC, 4'hD: g = GRP_ARITH;
					default: g = GRP_ARITH;
				endcase
			end
			4'h2, 4'h3, 4'hF: g = GRP_XFER;
			4'h5: begin
				case (fb[3:0])
					4'h0, 4'h1: g = GRP_MULDIV;
					4'h4, 4'h5, 4'h6, 4'hC, 4'hD, 4'hE, 4'hF: g = GRP_SUBR;
					4'h9, 4'hA, 4'hB: g = GRP_JUMP;
					default: g = GRP_ILLEGAL;
				endcase
			end
			4'h6: begin
				case (fb[3:0])
					4'h0, 4'h1, 4'h2, 4'h3, 4'h7: g = GRP_BIT;
					4'h4, 4'h5, 4'h6: g = GRP_ILLEGAL;
					default: g = GRP_XFER;
				endcase
				if (fb == `ODSC_OPC_PERIPH && w[6:4] == `ODSC_PERIPH_SUB) begin
					g = w[`ODSC_PAIR_BIT] ? GRP_PERIPH_WRITE : GRP_PERIPH_READ;
				end
			end
			4'h7: begin
				case (fb[3:0])
					4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: g = GRP_BIT;
					4'hC, 4'hD, 4'hE, 4'hF: g = GRP_BIT;
					default: g = GRP_ILLEGAL;
				endcase
			end
			4'h8, 4'h9, 4'hA, 4'hB: g = GRP_ARITH;
			4'hC, 4'hD, 4'hE: g = GRP_LOGIC;
			default: g = GRP_ILLEGAL;
		endcase
		return g;
	endfunction

	// First bytes shared by two instructions
	function automatic logic isPaired(input logic [7:0] fb);
		logic p;
		p = 1'b0;
		case (fb)
			8'h10, 8'h11, 8'h12, 8'h13, 8'h17, 8'h67, 8'h74, 8'h75, 8'h76, 8'h77: p = 1'b1;
			default: p = 1'b0;
		endcase
		return p;
	endfunction

	function automatic odsc_decode_type decodeWord(input logic [15:0] w);
		odsc_decode_type d;
		logic [7:0] fb;
		fb = w[`ODSC_FB_HI:`ODSC_FB_LO];
		d.group = rowGroup(fb, w);
		d.cond = COND_ALWAYS;
		d.paired = isPaired(fb);
		d.variant = d.paired & w[`ODSC_PAIR_BIT];
		if (fb[7:4] == `ODSC_BRANCH_NIBBLE) begin
			d.group = GRP_BRANCH;
			d.cond = odsc_cond_type'(fb[3:0]);
		end
		return d;
	endfunction

	always_comb begin
		next_state = state;
		next_state.valid = instrValid;
		if (instrValid) begin
			next_state.dec = decodeWord(instrWord);
			next_state.execStates = sumStates;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= '{valid: 1'b0, dec: '{group: GRP_ILLEGAL, cond: COND_ALWAYS,
				paired: 1'b0, variant: 1'b0}, execStates: `ODSC_RST_STATES};
		end else begin
			state <= next_state;
		end
	end

	assign decValid = state.valid;
	assign group = state.dec.group;
	assign cond = state.dec.cond;
	assign paired = state.dec.paired;
	assign variant = state.dec.variant;
	assign execStates = state.execStates;

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence reqByte(logic [7:0] b);
		instrValid && instrWord[15:8] == b;
	endsequence

	sequence fetchOnly(odsc_loc_type l);
		instrValid && counts == odsc_counts_type'({4'h1, 20'h0}) && locs.fetch == l;
	endsequence

	first_byte_a: assert property (reqByte(8'hF3) |=> decValid && group == GRP_XFER)
		else $error("first byte F row not register transfer");
	pair_select_a: assert property (reqByte(8'h10) |=> paired
		&& variant == $past(instrWord[7])) else $error("pair bit not followed");
	branch_cond_a: assert property (instrValid && instrWord[15:12] == 4'h4
		|=> group == GRP_BRANCH && cond == odsc_cond_type'($past(instrWord[11:8])))
		else $error("short jump condition wrong");
	alias_same_a: assert property (reqByte(8'h44) |=> cond == COND_CARRY_CLEAR)
		else $error("alias jump decoded differently");
	push_pop_a: assert property (reqByte(8'h6D) |=> group == GRP_XFER)
		else $error("stack transfer not register transfer");
	periph_split_a: assert property (instrValid && instrWord[15:8] == 8'h6A
		&& instrWord[6:4] == 3'h4
		|=> group == ($past(instrWord[7]) ? GRP_PERIPH_WRITE : GRP_PERIPH_READ))
		else $error("peripheral transfer not separated");
	zero_counts_a: assert property (instrValid && counts == '0 |=> execStates == 16'h0000)
		else $error("empty counts give nonzero states");
	onchip_fetch_a: assert property (fetchOnly(LOC_ONCHIP) |=> execStates == 16'h0002)
		else $error("on-chip fetch not two states");
	ext_fetch_a: assert property (fetchOnly(LOC_EXTERNAL)
		|=> execStates == 16'(16'h0006 + 16'($past(waitStates)) * 16'h0002))
		else $error("external word cycle not 6+2m");
	reg_byte_a: assert property (instrValid && locs.byteAccess == LOC_REGFIELD
		&& counts == odsc_counts_type'({12'h0, 4'h2, 8'h0}) |=> execStates == 16'h0006)
		else $error("register field byte not three states");
	internal_op_a: assert property (instrValid
		&& counts == odsc_counts_type'({20'h0, 4'h3}) |=> execStates == 16'h0003)
		else $error("internal cycle not one state");
	hold_idle_a: assert property (!instrValid |=> !decValid && $stable(execStates))
		else $error("outputs moved without request");

	// Answer timing, unshared bytes, non-jump conditions and single-type sums
	valid_follow_a: assert property (instrValid |=> decValid)
		else $error("request not answered in one cycle");
	unpaired_bit_a: assert property (reqByte(8'h0C) |=> !paired && !variant)
		else $error("unshared first byte marked as pair");
	other_cond_a: assert property (instrValid && instrWord[15:12] != 4'h4
		|=> group != GRP_BRANCH && cond == COND_ALWAYS)
		else $error("non jump row given a condition");
	alias_never_a: assert property (reqByte(8'h41) |=> cond == COND_NEVER)
		else $error("false jump alias decoded differently");
	alias_set_a: assert property (reqByte(8'h45) |=> cond == COND_CARRY_SET)
		else $error("lower jump alias decoded differently");
	move_row_a: assert property (instrValid && instrWord[15:12] == 4'h2 |=> group == GRP_XFER)
		else $error("move row not register transfer");
	periph_other_a: assert property (instrValid && instrWord[15:8] == 8'h6A
		&& instrWord[6:4] != 3'h4 |=> group == GRP_XFER)
		else $error("plain transfer taken as peripheral");
	reg_word_a: assert property (instrValid && locs.wordAccess == LOC_REGFIELD
		&& counts == odsc_counts_type'({16'h0, 4'h1, 4'h0}) |=> execStates == 16'h0006)
		else $error("register field word not six states");
	ext_byte_a: assert property (instrValid && locs.byteAccess == LOC_EXTERNAL
		&& counts == odsc_counts_type'({12'h0, 4'h1, 8'h0})
		|=> execStates == 16'(16'h0003 + 16'($past(waitStates))))
		else $error("external byte cycle not 3+m");
	ext_branch_a: assert property (instrValid && locs.branchRead == LOC_EXTERNAL
		&& counts == odsc_counts_type'({4'h0, 4'h1, 16'h0})
		|=> execStates == 16'(16'h0006 + 16'($past(waitStates)) * 16'h0002))
		else $error("external branch read not 6+2m");
	onchip_stack_a: assert property (instrValid && locs.stack == LOC_ONCHIP
		&& counts == odsc_counts_type'({8'h0, 4'h2, 12'h0}) |=> execStates == 16'h0004)
		else $error("on-chip stack cycle not two states");

endmodule // odsc_decoder

// [test/tb_odsc_decoder.sv]
// Self-checking bench for the opcode decoder and execution-state calculator.
// Assumes core/odsc_pkg.sv and core/odsc_decoder.sv are compiled first.
`timescale 1ns/10ps
module tb_odsc_decoder import odsc_pkg::*; ;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic instrValid = 1'b0;
	logic [15:0] instrWord = 16'h0000;
	odsc_counts_type counts = '0;
	odsc_locs_type locs = '0;
	logic [3:0] waitStates = 4'h0;
	logic decValid;
	logic paired;
	logic variant;
	odsc_group_type group;
	odsc_cond_type cond;
	logic [15:0] execStates;
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;
	logic [7:0] pairTab [10] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h17,
		8'h67, 8'h74, 8'h75, 8'h76, 8'h77};
	odsc_group_type pairGrp [10] = '{GRP_SHIFT, GRP_SHIFT, GRP_SHIFT, GRP_SHIFT, GRP_LOGIC,
		GRP_BIT, GRP_BIT, GRP_BIT, GRP_BIT, GRP_BIT};

	odsc_decoder dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .instrValid(instrValid),
		.instrWord(instrWord), .counts(counts), .locs(locs), .waitStates(waitStates),
		.decValid(decValid), .group(group), .cond(cond), .paired(paired),
		.variant(variant), .execStates(execStates));

	always #50 ref_clk = ~ref_clk;

	function automatic odsc_counts_type cn(input int i, j, k, l, m, n);
		return '{i[3:0], j[3:0], k[3:0], l[3:0], m[3:0], n[3:0]};
	endfunction

	function automatic odsc_locs_type lc(input odsc_loc_type a, b, c, d, e);
		return '{a, b, c, d, e};
	endfunction

	task automatic test_done();
		if (n_errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One request, then the answer is looked at one cycle later
	task automatic send(input logic [15:0] w, input odsc_counts_type c,
		input odsc_locs_type l, input logic [3:0] m);
		@(posedge ref_clk);
		instrValid <= 1'b1;
		instrWord <= w;
		counts <= c;
		locs <= l;
		waitStates <= m;
		@(posedge ref_clk);
		instrValid <= 1'b0;
		#1;
		chk("decValid", decValid, 1'b1);
	endtask

	task automatic dec(input logic [15:0] w, input odsc_group_type g, input logic p,
		input logic v);
		send(w, '0, '0, 4'h0);
		chk("group", group, g);
		chk("paired", paired, p);
		chk("variant", variant, v);
	endtask

	task automatic st(input odsc_counts_type c, input odsc_locs_type l,
		input logic [3:0] m, input logic [15:0] e);
		send(16'h0800, c, l, m);
		chk("execStates", execStates, e);
	endtask

	task automatic test_jumps();
		for (int i = 0; i < 16; i++) begin
			dec({4'h4, i[3:0], 8'h80}, GRP_BRANCH, 1'b0, 1'b0);
			chk("cond", cond, i[15:0]);
		end
		dec(16'h4400, GRP_BRANCH, 1'b0, 1'b0);
		chk("cond", cond, COND_CARRY_CLEAR);
	endtask

	task automatic test_pairs();
		for (int i = 0; i < 10; i++) begin
			dec({pairTab[i], 8'h00}, pairGrp[i], 1'b1, 1'b0);
			dec({pairTab[i], 8'h80}, pairGrp[i], 1'b1, 1'b1);
		end
		dec(16'h0C80, GRP_XFER, 1'b0, 1'b0);
	endtask

	task automatic test_transfers();
		dec(16'h6A40, GRP_PERIPH_READ, 1'b0, 1'b0);
		dec(16'h6AC0, GRP_PERIPH_WRITE, 1'b0, 1'b0);
		dec(16'h6A00, GRP_XFER, 1'b0, 1'b0);
		dec(16'h6DF0, GRP_XFER, 1'b0, 1'b0);
		dec(16'h6D70, GRP_XFER, 1'b0, 1'b0);
		dec(16'h2A00, GRP_XFER, 1'b0, 1'b0);
	endtask

	task automatic test_groups();
		dec(16'h0000, GRP_CONTROL, 1'b0, 1'b0);
		dec(16'h0380, GRP_CCR, 1'b0, 1'b0);
		dec(16'h0E00, GRP_ARITH, 1'b0, 1'b0);
		dec(16'h9F00, GRP_ARITH, 1'b0, 1'b0);
		dec(16'hC500, GRP_LOGIC, 1'b0, 1'b0);
		dec(16'h5100, GRP_MULDIV, 1'b0, 1'b0);
		dec(16'h5C00, GRP_SUBR, 1'b0, 1'b0);
		dec(16'h5A00, GRP_JUMP, 1'b0, 1'b0);
		dec(16'h7C80, GRP_BIT, 1'b0, 1'b0);
		dec(16'h6500, GRP_ILLEGAL, 1'b0, 1'b0);
		dec(16'h7800, GRP_ILLEGAL, 1'b0, 1'b0);
	endtask

	task automatic test_states();
		st(cn(1, 0, 0, 0, 0, 0), lc(LOC_EXTERNAL, LOC_ONCHIP, LOC_ONCHIP, LOC_ONCHIP,
			LOC_ONCHIP), 4'h1, 16'h0008);
		@(posedge ref_clk);
		#1;
		chk("decValid", decValid, 1'b0);
		chk("execStates", execStates, 16'h0008);
		st(cn(2, 0, 0, 2, 0, 0), lc(LOC_EXTERNAL, LOC_ONCHIP, LOC_ONCHIP, LOC_REGFIELD,
			LOC_ONCHIP), 4'h1, 16'h0016);
		st(cn(2, 1, 1, 0, 0, 0), lc(LOC_EXTERNAL, LOC_EXTERNAL, LOC_EXTERNAL, LOC_ONCHIP,
			LOC_ONCHIP), 4'h1, 16'h0020);
		st(cn(0, 0, 0, 2, 0, 0), {5{LOC_EXTERNAL}}, 4'h2, 16'h000A);
		st(cn(0, 0, 0, 1, 0, 0), {5{LOC_EXTERNAL}}, 4'h0, 16'h0003);
		st(cn(0, 0, 0, 0, 1, 0), {5{LOC_EXTERNAL}}, 4'hF, 16'h0024);
		st(cn(0, 1, 0, 0, 0, 0), {5{LOC_EXTERNAL}}, 4'h4, 16'h000E);
		st(cn(0, 1, 0, 3, 1, 0), {5{LOC_REGFIELD}}, 4'h5, 16'h0015);
		st(cn(0, 0, 0, 0, 1, 0), {5{LOC_REGFIELD}}, 4'h3, 16'h0006);
		st(cn(3, 1, 2, 1, 1, 4), {5{LOC_ONCHIP}}, 4'hF, 16'h0014);
		st(cn(0, 0, 2, 0, 0, 0), {5{LOC_ONCHIP}}, 4'h9, 16'h0004);
		st(cn(0, 0, 0, 0, 0, 15), {5{LOC_EXTERNAL}}, 4'h7, 16'h000F);
		st(cn(0, 0, 0, 0, 0, 0), {5{LOC_EXTERNAL}}, 4'h9, 16'h0000);
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			test_done();
		end
	end

	initial begin
		repeat (2) @(posedge ref_clk);
		#1;
		chk("decValid", decValid, 1'b0);
		chk("execStates", execStates, 16'h0000);
		@(posedge ref_clk);
		rst_b <= 1'b1;
		test_jumps();
		test_pairs();
		test_transfers();
		test_groups();
		test_states();
		test_done();
	end
endmodule // tb_odsc_decoder
